// >>> verilog/loop_ctrl_pkg.sv
package loop_ctrl_pkg;

  localparam int AXI_ADDR_W = 8;

  // Printed offsets are word indices; byte address is index times four
  localparam logic [7:0] CTRL1_INDEX = 8'h1b;
  localparam logic [7:0] CTRL2_INDEX = 8'h1c;
  localparam logic [7:0] CTRL1_RESET = 8'h93;
  localparam logic [7:0] CTRL2_RESET = 8'hf5;
  // Reserved bit 6 of the first register is not stored
  localparam logic [7:0] CTRL1_WMASK = 8'hbf;

  localparam int BOOST_BIT = 7;
  localparam int CM_BIT = 5;
  localparam int DT_LSB = 0;
  localparam int DT_W = 5;
  localparam int INPUT_MODE_BIT = 7;
  localparam int BRAKE_STAB_BIT = 6;
  localparam int SAMPLE_LSB = 4;
  localparam int BLANK_LSB = 2;
  localparam int DECAY_LSB = 0;

  // Drive times counted in 0.1 ms units
  localparam logic [6:0] LRA_BASE_UNITS = 7'h05;
  localparam logic [6:0] ERM_BASE_UNITS = 7'h0a;
  localparam logic [6:0] UNITS_MIN = 7'h01;
  localparam logic [6:0] UNITS_MAX = 7'h7f;
  localparam int CLK_PERIOD_NS = 8;
  localparam int DRIVE_UNIT_NS = 100000;
  localparam int DRIVE_UNIT_CYCLES = DRIVE_UNIT_NS / CLK_PERIOD_NS;
  localparam int CYCLES_PER_US = 1000 / CLK_PERIOD_NS;
  localparam int SAMPLE_BASE_US = 150;
  localparam int SAMPLE_STEP_US = 50;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {GAIN_NORMAL, GAIN_BOOST, GAIN_REDUCED} gain_e;
  typedef enum logic [1:0] {SEL_NONE, SEL_CTRL1, SEL_CTRL2} reg_sel_e;

  typedef struct packed {
    logic [AXI_ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [AXI_ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_s;

  function automatic reg_sel_e reg_select(logic [AXI_ADDR_W-1:0] addr);
    if (addr[AXI_ADDR_W-1:2] == CTRL1_INDEX[AXI_ADDR_W-3:0]) begin
      return SEL_CTRL1;
    end
    if (addr[AXI_ADDR_W-1:2] == CTRL2_INDEX[AXI_ADDR_W-3:0]) begin
      return SEL_CTRL2;
    end
    return SEL_NONE;
  endfunction : reg_select

  function automatic logic [6:0] seed_units(logic lra, logic [4:0] code);
    if (lra) begin
      return 7'(code) + LRA_BASE_UNITS;
    end
    return {1'b0, code, 1'b0} + ERM_BASE_UNITS;
  endfunction : seed_units

  function automatic logic [15:0] sample_cycles(logic [1:0] code);
    return 16'((SAMPLE_BASE_US + SAMPLE_STEP_US * int'(code)) * CYCLES_PER_US);
  endfunction : sample_cycles

endpackage : loop_ctrl_pkg

// >>> verilog/haptic_loop_control_regs.sv
// How it works
// - Boost bit set raises loop gain while the actuator is overdriven.
// - Common-mode bit drives 0.9 V on input pin, analog mode only.
// - LRA mode: drive-time code only seeds; tracking then trims continuously.
// - LRA initial drive time is code times 0.1 ms plus 0.5 ms.
// - ERM back-EMF sample period is code times 0.2 ms plus 1 ms.
// - Second register bit 7 picks unidirectional (0) or bidirectional (1).
// - Unidirectional: feedback decides braking; full range positive, extra bit.
// - Unidirectional output scales linearly from zero to full scale.
// - Bidirectional open loop: below half brakes, half is zero, above drives.
// - Brake_gain_reduction bit lowers loop gain as braking nears completion.
// - Sample time code 0..3 selects 150, 200, 250 or 300 us.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module haptic_loop_control_regs
  import loop_ctrl_pkg::*;
#(
  parameter int UNIT_CYCLES = DRIVE_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire axi_req_s axi_req,
  output axi_rsp_s axi_rsp,
  // Loop status from the drive engine
  input wire logic lra_mode,
  input wire logic analog_input_mode,
  input wire logic closed_loop,
  input wire logic playback_start,
  input wire logic tune_up,
  input wire logic tune_down,
  input wire logic overdrive_active,
  input wire logic braking_active,
  input wire logic brake_near_done,
  input wire logic brake_request,
  input wire logic [7:0] amp_in,
  // Loop controls
  output gain_e loop_gain,
  output logic input_common_mode_enable,
  output logic input_sign_interpretation,
  output logic [6:0] drive_units,
  output logic drive_edge,
  output logic [8:0] drive_level,
  output logic brake_out,
  output logic [15:0] sample_window,
  output logic [1:0] blanking_code,
  output logic [1:0] current_decay_period
);

  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [AXI_ADDR_W-1:0] awaddr;
    logic [7:0] wbyte;
    logic wlane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] rbyte;
    logic [1:0] rresp;
    logic [6:0] units;
    logic [15:0] tick_cnt;
    logic [6:0] unit_cnt;
    logic edge_p;
    gain_e gain;
    logic cm_en;
    logic [8:0] level;
    logic brake;
    logic [15:0] window;
    logic live;
  } state_s;

  state_s s_q;
  state_s s_d;
  logic wr_fire;
  reg_sel_e wr_sel;
  reg_sel_e rd_sel;
  logic [7:0] amp;

  assign wr_fire = s_q.aw_have & s_q.w_have & ~s_q.bvalid;
  assign wr_sel = reg_select(s_q.awaddr);
  assign rd_sel = reg_select(axi_req.araddr);
  assign amp = amp_in;

  always_comb begin
    logic seed;
    seed = 1'b0;
    s_d = s_q;
    s_d.edge_p = 1'b0;
    s_d.live = 1'b1;

    // Write channels taken in either order, response after both
    if (s_q.bvalid && axi_req.bready) begin
      s_d.bvalid = 1'b0;
    end
    if (axi_req.awvalid && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.wbyte = axi_req.wdata[7:0];
      s_d.wlane0 = axi_req.wstrb[0];
    end
    if (wr_fire) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      unique case (wr_sel)
        SEL_CTRL1: begin
          if (s_q.wlane0) begin
            s_d.ctrl1 = s_q.wbyte & CTRL1_WMASK;
            seed = 1'b1;
          end
        end
        SEL_CTRL2: begin
          if (s_q.wlane0) begin
            s_d.ctrl2 = s_q.wbyte;
          end
        end
        SEL_NONE: begin
          s_d.bresp = RESP_SLVERR;
        end
      endcase
    end
    s_d.awready = ~s_d.aw_have & ~s_d.bvalid;
    s_d.wready = ~s_d.w_have & ~s_d.bvalid;

    // Read channel
    if (s_q.rvalid && axi_req.rready) begin
      s_d.rvalid = 1'b0;
    end
    if (axi_req.arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      unique case (rd_sel)
        SEL_CTRL1: s_d.rbyte = s_q.ctrl1;
        SEL_CTRL2: s_d.rbyte = s_q.ctrl2;
        SEL_NONE: begin
          s_d.rbyte = 8'h00;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end
    s_d.arready = ~s_d.rvalid;

    // ERM period follows the code; LRA code only seeds the tracker
    if (!lra_mode || seed || playback_start) begin
      s_d.units = seed_units(lra_mode, s_d.ctrl1[DT_LSB +: DT_W]);
    end else if (tune_up && s_q.units != UNITS_MAX) begin
      s_d.units = s_q.units + 7'h01;
    end else if (tune_down && s_q.units != UNITS_MIN) begin
      s_d.units = s_q.units - 7'h01;
    end

    // Half-period timer in 0.1 ms units
    if (seed || playback_start) begin
      s_d.tick_cnt = 16'h0000;
      s_d.unit_cnt = 7'h00;
    end else if (s_q.tick_cnt == 16'(UNIT_CYCLES - 1)) begin
      s_d.tick_cnt = 16'h0000;
      if (s_q.unit_cnt + 7'h01 >= s_q.units) begin
        s_d.unit_cnt = 7'h00;
        s_d.edge_p = 1'b1;
      end else begin
        s_d.unit_cnt = s_q.unit_cnt + 7'h01;
      end
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 16'h0001;
    end

    // Boost wins: overdrive and braking never overlap in practice
    if (overdrive_active && s_q.ctrl1[BOOST_BIT]) begin
      s_d.gain = GAIN_BOOST;
    end else if (braking_active && brake_near_done &&
                 s_q.ctrl2[BRAKE_STAB_BIT]) begin
      s_d.gain = GAIN_REDUCED;
    end else begin
      s_d.gain = GAIN_NORMAL;
    end

    // Gated so a stray setting cannot bias a digital input
    s_d.cm_en = s_q.ctrl1[CM_BIT] & analog_input_mode;

    // Input interpretation
    if (!s_q.ctrl2[INPUT_MODE_BIT]) begin
      s_d.level = {1'b0, amp};
      s_d.brake = brake_request;
    end else if (!closed_loop) begin
      s_d.level = {~amp[7], amp[6:0], 1'b0};
      s_d.brake = ~amp[7];
    end else begin
      s_d.level = amp[7] ? {1'b0, amp[6:0], 1'b0} : 9'h000;
      s_d.brake = brake_request;
    end

    s_d.window = sample_cycles(s_q.ctrl2[SAMPLE_LSB +: 2]);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.ctrl1 <= CTRL1_RESET;
      s_q.ctrl2 <= CTRL2_RESET;
      s_q.units <= LRA_BASE_UNITS;
      s_q.gain <= GAIN_NORMAL;
    end else begin
      s_q <= s_d;
    end
  end

  assign axi_rsp.awready = s_q.awready;
  assign axi_rsp.wready = s_q.wready;
  assign axi_rsp.bvalid = s_q.bvalid;
  assign axi_rsp.bresp = s_q.bresp;
  assign axi_rsp.arready = s_q.arready;
  assign axi_rsp.rvalid = s_q.rvalid;
  assign axi_rsp.rdata = {24'h000000, s_q.rbyte};
  assign axi_rsp.rresp = s_q.rresp;
  assign loop_gain = s_q.gain;
  assign input_common_mode_enable = s_q.cm_en;
  assign input_sign_interpretation = s_q.ctrl2[INPUT_MODE_BIT];
  assign drive_units = s_q.units;
  assign drive_edge = s_q.edge_p;
  assign drive_level = s_q.level;
  assign brake_out = s_q.brake;
  assign sample_window = s_q.window;
  assign blanking_code = s_q.ctrl2[BLANK_LSB +: 2];
  assign current_decay_period = s_q.ctrl2[DECAY_LSB +: 2];

  default clocking cb @(posedge aclk); endclocking
  // Release edge still shows reset state; checks start one edge later
  default disable iff (!aresetn || !s_q.live);

  a_boost_gain: assert property (
    overdrive_active && s_q.ctrl1[BOOST_BIT] |=> loop_gain == GAIN_BOOST)
    else $error("boost gain missing in overdrive");

  a_cm_gate: assert property (
    ##1 input_common_mode_enable ==
        $past(s_q.ctrl1[CM_BIT] && analog_input_mode))
    else $error("common-mode enable wrong");

  a_lra_track: assert property (
    lra_mode && !playback_start && !wr_fire && tune_up &&
    drive_units != UNITS_MAX |=> drive_units == $past(drive_units) + 7'h01)
    else $error("drive time not trimmed up");

  a_lra_seed: assert property (
    lra_mode && playback_start ##1 !wr_fire |->
    drive_units == seed_units(1'b1, s_q.ctrl1[DT_LSB +: DT_W]))
    else $error("LRA seed wrong");

  a_erm_period: assert property (
    !lra_mode |=> drive_units == seed_units(1'b0, s_q.ctrl1[DT_LSB +: DT_W]))
    else $error("ERM sample period wrong");

  a_unidir_level: assert property (
    !s_q.ctrl2[INPUT_MODE_BIT] |=>
    drive_level == {1'b0, $past(amp)} && brake_out == $past(brake_request))
    else $error("unidirectional level wrong");

  a_bidir_open: assert property (
    s_q.ctrl2[INPUT_MODE_BIT] && !closed_loop |=>
    $signed(drive_level) == 2 * ($signed({1'b0, $past(amp)}) - 128) &&
    brake_out == ($past(amp) < 8'h80))
    else $error("bidirectional level wrong");

  a_brake_gain: assert property (
    !overdrive_active && braking_active && brake_near_done &&
    s_q.ctrl2[BRAKE_STAB_BIT] |=> loop_gain == GAIN_REDUCED)
    else $error("brake gain not reduced");

  a_sample_time: assert property (
    $stable(s_q.ctrl2) [*2] |->
    sample_window == 16'(125 * (150 + 50 * int'(s_q.ctrl2[5:4]))))
    else $error("sample window wrong");

  a_mode_bit: assert property (
    wr_fire && wr_sel == SEL_CTRL2 && s_q.wlane0 |=>
    input_sign_interpretation == $past(s_q.wbyte[INPUT_MODE_BIT]))
    else $error("input mode bit not written");

  a_write_resp: assert property (
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
    |-> ##[1:3] axi_rsp.bvalid)
    else $error("write response late");

  c_write: cover property (axi_rsp.bvalid && axi_req.bready);
  c_read: cover property (axi_rsp.rvalid && axi_req.rready);
  c_edge: cover property (drive_edge);
  c_boost: cover property (loop_gain == GAIN_BOOST);

endmodule : haptic_loop_control_regs

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
  import loop_ctrl_pkg::*;
  localparam logic [7:0] A1 = 8'h6c;
  localparam logic [7:0] A2 = 8'h70;
  localparam logic [7:0] BAD = 8'h74;
  localparam int UC = 4;
  logic aclk = 0;
  logic aresetn = 0;
  axi_req_s req = '0;
  axi_rsp_s rsp;
  logic lra = 0, ana = 0, cl = 0, pb = 0, tup = 0, tdn = 0;
  logic od = 0, brk = 0, near = 0, breq = 0;
  logic [7:0] amp = 8'h00;
  gain_e gain;
  logic cm, sgn, dedge, bo;
  logic [6:0] du;
  logic [8:0] dl;
  logic [15:0] sw;
  logic [1:0] blk, dec, r;
  logic [31:0] d, v;
  int n_errors = 0, compares = 0, seed = 32'h4e56;
  int mu, m1 = 8'h93, m2 = 8'hf5;

  haptic_loop_control_regs #(.UNIT_CYCLES(UC)) i_haptic_loop_control_regs (
    .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .lra_mode(lra), .analog_input_mode(ana), .closed_loop(cl),
    .playback_start(pb), .tune_up(tup), .tune_down(tdn),
    .overdrive_active(od), .braking_active(brk),
    .brake_near_done(near), .brake_request(breq), .amp_in(amp),
    .loop_gain(gain), .input_common_mode_enable(cm),
    .input_sign_interpretation(sgn), .drive_units(du),
    .drive_edge(dedge), .drive_level(dl), .brake_out(bo),
    .sample_window(sw), .blanking_code(blk),
    .current_decay_period(dec));

  initial begin
    forever #4 aclk = ~aclk;
  end

  task give_verdict;
    $display("Errors %0d, compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  task chk_out(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_out

  task chk_bus(input logic [33:0] g, input logic [33:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_bus

  // Address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] x);
    int k;
    logic aw, w, dn;
    aw = 1;
    w = 1;
    dn = 0;
    k = 0;
    @(posedge aclk);
    req.awaddr <= a;
    req.awvalid <= 1;
    req.wdata <= x;
    // Bit 8 of the word stands in for the lane-0 strobe
    req.wstrb <= {3'h7, x[8]};
    req.wvalid <= 1;
    req.bready <= 1;
    while (!dn && k < 100) begin
      @(posedge aclk);
      k++;
      if (aw && rsp.awready) begin
        aw = 0;
        req.awvalid <= 0;
      end
      if (w && rsp.wready) begin
        w = 0;
        req.wvalid <= 0;
      end
      if (rsp.bvalid) begin
        r = rsp.bresp;
        req.bready <= 0;
        dn = 1;
      end
    end
    if (!dn) begin
      n_errors++;
      give_verdict();
    end
  endtask : wr

  task rd(input logic [7:0] a);
    int k;
    logic ar, dn;
    ar = 1;
    dn = 0;
    k = 0;
    @(posedge aclk);
    req.araddr <= a;
    req.arvalid <= 1;
    req.rready <= 1;
    while (!dn && k < 100) begin
      @(posedge aclk);
      k++;
      if (ar && rsp.arready) begin
        ar = 0;
        req.arvalid <= 0;
      end
      if (rsp.rvalid) begin
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 0;
        dn = 1;
      end
    end
    if (!dn) begin
      n_errors++;
      give_verdict();
    end
  endtask : rd

  // Outputs lag inputs by one cycle; three edges leave margin
  task settle;
    repeat (3) @(posedge aclk);
    #1;
  endtask : settle

  // Two drive edges lie one drive time apart
  task chk_period(input int want);
    int k;
    int n;
    k = 0;
    n = 0;
    while (n < 2 && k < 4000) begin
      @(posedge aclk);
      k++;
      if (dedge && n == 1) begin
        chk_out(32'(k), 32'(want));
      end
      if (dedge) begin
        n++;
        k = 0;
      end
    end
    if (n < 2) begin
      n_errors++;
      give_verdict();
    end
  endtask : chk_period

  task check_all;
    logic [8:0] el;
    logic eb;
    gain_e eg;
    if (!lra) mu = 2 * (m1 & 31) + 10;
    eg = (od && m1[7]) ? GAIN_BOOST :
         (brk && near && m2[6]) ? GAIN_REDUCED : GAIN_NORMAL;
    if (!m2[7]) begin
      el = {1'b0, amp};
      eb = breq;
    end else if (!cl) begin
      el = 9'(2 * (amp - 128));
      eb = amp < 128;
    end else begin
      el = (amp >= 128) ? 9'(2 * (amp - 128)) : 9'h000;
      eb = breq;
    end
    chk_out(32'(gain), 32'(eg));
    chk_out(32'(cm), 32'(m1[5] & ana));
    chk_out(32'(sgn), 32'(m2[7]));
    chk_out(32'(du), mu);
    chk_out(32'(dl), 32'(el));
    chk_out(32'(bo), 32'(eb));
    chk_out(32'(sw), (150 + 50 * m2[5:4]) * 125);
    chk_out(32'(blk), 32'(m2[3:2]));
    chk_out(32'(dec), 32'(m2[1:0]));
  endtask : check_all

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    settle();
    check_all();
    rd(A1);
    chk_bus({r, d}, {RESP_OKAY, 32'(m1)});
    rd(A2);
    chk_bus({r, d}, {RESP_OKAY, 32'(m2)});
    rd(BAD);
    chk_bus({r, d}, {RESP_SLVERR, 32'h0});
    wr(BAD, 32'hff);
    chk_bus({r, 32'h0}, {RESP_SLVERR, 32'h0});
    for (int i = 0; i < 12; i++) begin
      d = $random(seed);
      v = $random(seed);
      // Common-mode bit only while the pin stays analog
      if (!d[0] || !ana) begin
        v[5] = 0;
        v[8] = 1;
      end
      wr(A1, v);
      chk_bus({r, 32'h0}, {RESP_OKAY, 32'h0});
      if (v[8]) m1 = v[7:0] & 8'hbf;
      v = $random(seed);
      wr(A2, v);
      if (v[8]) m2 = v[7:0];
      @(posedge aclk);
      ana <= d[0];
      cl <= d[1] | ~m2[7];
      od <= d[2];
      brk <= d[3];
      near <= d[3];
      breq <= d[4];
      amp <= (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : (i == 2) ? 8'hff : d[15:8];
      settle();
      check_all();
      rd(A1);
      chk_bus({r, d}, {RESP_OKAY, 32'(m1)});
    end
    // Seed then track: the code only starts the tracker off
    @(posedge aclk);
    lra <= 1;
    pb <= 1;
    @(posedge aclk);
    pb <= 0;
    mu = (m1 & 31) + 5;
    settle();
    check_all();
    chk_period(mu * UC);
    @(posedge aclk);
    tup <= 1;
    @(posedge aclk);
    tup <= 0;
    mu++;
    settle();
    check_all();
    chk_period(mu * UC);
    // 200 Hz actuator: 5 ms period, so 2.5 ms drive, code 0x14
    wr(A1, 32'h194);
    m1 = 8'h94;
    mu = 25;
    settle();
    check_all();
    @(posedge aclk);
    tdn <= 1;
    @(posedge aclk);
    tdn <= 0;
    mu--;
    settle();
    check_all();
    give_verdict();
  end
endmodule : tb
